// File: core/mcsi_core.v
// Settings layer of a smart modem command interpreter with an APB slave.
// Assumes one 50 MHz clock, a synchronous active-low reset, and pins for
// the terminal-ready and received-carrier lines that are asynchronous.
//
// Implementation choices: the APB slave port and the register offsets.
`include "mcsi_defs.vh"

module mcsi_core #(
	parameter UNIT_CYC = `MCSI_UNIT_10MS_CYC // Cycles per 10 ms unit.
) (
	input wire clk,
	input wire resetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire terminal_ready_pin,
	input wire rx_carrier_pin,
	input wire long_space_seen,
	input wire ring_pulse,
	input wire outcome_valid,
	input wire [3:0] outcome_code,
	input wire [1:0] connect_rate,
	input wire [7:0] dial_char,
	input wire dial_char_valid,
	input wire [1:0] frame_rate,
	input wire [2:0] frame_format,
	output reg carrier_detect_ff,
	output reg hangup_ff,
	output reg command_state_ff,
	output reg modem_reset_ff,
	output reg answer_ff,
	output reg nv_store_ff,
	output reg [31:0] nv_data_ff,
	output reg [5:0] dial_action_ff,
	output reg format_ok_ff,
	output reg result_valid_ff,
	output reg [3:0] result_code_ff,
	output reg result_verbose_ff
);

	// Parameter registers indexed by their number, 0 to 37.
	reg [7:0] sreg_ff [0:37];
	// Control: level, verbose, carrier, terminal-ready option, long space.
	reg [8:0] ctrl_ff;
	reg [8:0] nxt_ctrl;
	// Ten-millisecond tick counter for the terminal-ready delay timer.
	reg [31:0] tick_cnt_ff;
	reg tick_ff;
	// Terminal-ready drop delay counter in 10 ms units.
	reg [7:0] tr_cnt_ff;
	reg tr_pending_ff;
	// Synchronisers for the asynchronous pins.
	reg [1:0] tr_sync_ff;
	reg [1:0] cd_sync_ff;
	reg tr_prev_ff;
	integer i;
	wire wr_en;
	wire rd_en;
	wire [5:0] idx;
	wire tr_fall;

	// Factory value of a parameter register by number.
	function [7:0] factory_val;
		input [5:0] n;
		begin
			case (n)
				6'd2: factory_val = `MCSI_RST_ESCAPE;
				6'd3: factory_val = `MCSI_RST_CR;
				6'd4: factory_val = `MCSI_RST_LF;
				6'd5: factory_val = `MCSI_RST_BS;
				6'd6: factory_val = `MCSI_RST_DIAL_TONE;
				6'd7: factory_val = `MCSI_RST_CARRIER_WAIT;
				6'd8: factory_val = `MCSI_RST_PAUSE;
				6'd9: factory_val = `MCSI_RST_CARRIER_VALID;
				6'd10: factory_val = `MCSI_RST_CARRIER_DROP;
				6'd11: factory_val = `MCSI_RST_TONE;
				6'd12: factory_val = `MCSI_RST_GUARD;
				6'd14: factory_val = `MCSI_RST_OPTION_A;
				6'd17: factory_val = `MCSI_RST_SPECIAL;
				6'd22: factory_val = `MCSI_RST_OPTION_C;
				6'd23: factory_val = `MCSI_RST_OPTION_D;
				6'd25: factory_val = `MCSI_RST_TR_DELAY;
				6'd26: factory_val = `MCSI_RST_CTS_DELAY;
				6'd27: factory_val = `MCSI_RST_OPTION_E;
				default: factory_val = 8'h00;
			endcase
		end
	endfunction

	// True for a register number that exists in the map.
	function implemented;
		input [5:0] n;
		begin
			implemented = (n <= 6'd12) || (n == 6'd14) || (n >= 6'd16 && n <= 6'd18) ||
				(n >= 6'd21 && n <= 6'd23) || (n >= 6'd25 && n <= 6'd27) || (n == 6'd37);
		end
	endfunction

	// Range clamp on a written value for registers with a limited range.
	function [7:0] clamp_val;
		input [5:0] n;
		input [7:0] v;
		begin
			clamp_val = v;
			if (n >= 6'd2 && n <= 6'd4 && v > `MCSI_MAX_ASCII) begin
				clamp_val = `MCSI_MAX_ASCII;
			end
			if (n == 6'd37 && v > `MCSI_MAX_SPEED) begin
				clamp_val = `MCSI_MAX_SPEED;
			end
		end
	endfunction

	// APB answers in the access cycle; unmapped addresses raise pslverr.
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & ~pwrite;
	assign idx = paddr[7:2];
	assign pslverr = psel & penable & ~((paddr < 8'hC0 && implemented(idx)) || (paddr >= `MCSI_OFF_CONTROL &&
		paddr <= `MCSI_OFF_DIAL_MOD));
	assign tr_fall = tr_prev_ff & ~tr_sync_ff[1];

	// Synchronise pins through two flip-flops before use.
	always @(posedge clk) begin
		if (!resetn) begin
			tr_sync_ff <= 2'b00;
			cd_sync_ff <= 2'b00;
			tr_prev_ff <= 1'b0;
		end else begin
			tr_sync_ff <= {tr_sync_ff[0], terminal_ready_pin};
			cd_sync_ff <= {cd_sync_ff[0], rx_carrier_pin};
			tr_prev_ff <= tr_sync_ff[1];
		end
	end

	// Control register next value: writes and option commands.
	always @* begin
		nxt_ctrl = ctrl_ff;
		if (wr_en && paddr == `MCSI_OFF_CONTROL) begin
			nxt_ctrl = pwdata[8:0];
		end
		if (wr_en && paddr == `MCSI_OFF_COMMAND) begin
			// A command without a value carries zero in pwdata[11:4].
			case (pwdata[3:0])
				`MCSI_CMD_LEVEL: nxt_ctrl[3:0] = (pwdata[11:4] > 8'd4) ? ctrl_ff[3:0] : pwdata[7:4];
				`MCSI_CMD_CARRIER: nxt_ctrl[5] = pwdata[4];
				`MCSI_CMD_TERMINAL: nxt_ctrl[7:6] = pwdata[5:4];
				`MCSI_CMD_LONG_SPACE: nxt_ctrl[8] = pwdata[4];
				`MCSI_CMD_FACTORY: nxt_ctrl = `MCSI_CTL_RST;
				default: nxt_ctrl = nxt_ctrl;
			endcase
		end
	end

	// Parameter registers, ring counting, factory recall and control.
	always @(posedge clk) begin
		if (!resetn || (wr_en && paddr == `MCSI_OFF_COMMAND && pwdata[3:0] == `MCSI_CMD_FACTORY)) begin
			for (i = 0; i < 38; i = i + 1) begin
				sreg_ff[i] <= factory_val(i[5:0]);
			end
			ctrl_ff <= `MCSI_CTL_RST;
		end else begin
			ctrl_ff <= nxt_ctrl;
			if (wr_en && paddr < 8'hC0 && implemented(idx)) begin
				sreg_ff[idx] <= clamp_val(idx, pwdata[7:0]);
			end
			// A ring wins over a software write to the ring counter.
			if (ring_pulse) begin
				sreg_ff[1] <= sreg_ff[1] + 8'd1;
			end
			// The counter clears on a modem reset or a hangup pulse.
			if (modem_reset_ff || hangup_ff) begin
				sreg_ff[1] <= 8'h00;
			end
		end
	end

	// Ten-millisecond tick used by the terminal-ready delay.
	always @(posedge clk) begin
		if (!resetn) begin
			tick_cnt_ff <= 32'h00000000;
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= (tick_cnt_ff == UNIT_CYC - 1);
			tick_cnt_ff <= (tick_cnt_ff == UNIT_CYC - 1) ? 32'h00000000 : tick_cnt_ff + 32'h00000001;
		end
	end

	// Carrier indication, answering and terminal-ready drop handling.
	always @(posedge clk) begin
		if (!resetn) begin
			carrier_detect_ff <= 1'b1;
			hangup_ff <= 1'b0;
			command_state_ff <= 1'b1;
			modem_reset_ff <= 1'b0;
			answer_ff <= 1'b0;
			tr_cnt_ff <= 8'h00;
			tr_pending_ff <= 1'b0;
		end else begin
			carrier_detect_ff <= ctrl_ff[`MCSI_CTL_CARRIER] ? cd_sync_ff[1] : 1'b1;
			hangup_ff <= 1'b0;
			modem_reset_ff <= 1'b0;
			// Answer once the ring count reaches a nonzero setting.
			answer_ff <= (sreg_ff[0] != 8'h00) && (sreg_ff[1] >= sreg_ff[0]);
			if (long_space_seen && ctrl_ff[`MCSI_CTL_LONG_SPACE]) begin
				hangup_ff <= 1'b1;
				command_state_ff <= 1'b1;
			end
			if (outcome_valid && outcome_code == `MCSI_EV_CONNECT) begin
				command_state_ff <= 1'b0;
			end
			// The drop must persist for the delay before it acts.
			if (tr_fall && ctrl_ff[7:6] != 2'd0) begin
				tr_pending_ff <= 1'b1;
				tr_cnt_ff <= sreg_ff[25];
			end else if (tr_pending_ff && tr_sync_ff[1]) begin
				tr_pending_ff <= 1'b0;
			end else if (tr_pending_ff && tick_ff) begin
				if (tr_cnt_ff == 8'h00) begin
					tr_pending_ff <= 1'b0;
					case (ctrl_ff[7:6])
						2'd1: command_state_ff <= 1'b1;
						2'd2: begin
							hangup_ff <= 1'b1;
							command_state_ff <= 1'b1;
						end
						2'd3: modem_reset_ff <= 1'b1;
						default: command_state_ff <= command_state_ff;
					endcase
				end else begin
					tr_cnt_ff <= tr_cnt_ff - 8'd1;
				end
			end
			if (wr_en && paddr == `MCSI_OFF_COMMAND && pwdata[3:0] == `MCSI_CMD_RESET) begin
				modem_reset_ff <= 1'b1;
				command_state_ff <= 1'b1;
			end
		end
	end

	// Store image, dial modifiers and character format check.
	always @(posedge clk) begin
		if (!resetn) begin
			nv_store_ff <= 1'b0;
			nv_data_ff <= 32'h00000000;
			dial_action_ff <= 6'h00;
			format_ok_ff <= 1'b0;
		end else begin
			nv_store_ff <= wr_en && paddr == `MCSI_OFF_COMMAND && pwdata[3:0] == `MCSI_CMD_STORE;
			if (wr_en && paddr == `MCSI_OFF_COMMAND && pwdata[3:0] == `MCSI_CMD_STORE) begin
				nv_data_ff <= {sreg_ff[26], sreg_ff[25], sreg_ff[14], sreg_ff[0]};
			end
			// One-hot action: delay, command, silence, stored, flash, tone; R sets all.
			dial_action_ff <= 6'h00;
			if (dial_char_valid) begin
				case (dial_char)
					8'h2C: dial_action_ff <= 6'h01;
					8'h3B: dial_action_ff <= 6'h02;
					8'h40: dial_action_ff <= 6'h04;
					8'h53, 8'h73: dial_action_ff <= 6'h08;
					8'h21: dial_action_ff <= 6'h10;
					8'h57, 8'h77: dial_action_ff <= 6'h20;
					8'h52, 8'h72: dial_action_ff <= 6'h3F;
					default: dial_action_ff <= 6'h00;
				endcase
			end
			// Formats 0-3: 7N2 7E1 7O1 8N1; 4-5: 8E1 8O1 at 300 only.
			format_ok_ff <= (frame_format <= 3'd3) || (frame_format <= 3'd5 && frame_rate == 2'd0);
		end
	end

	// Result code filter by level and format.
	always @(posedge clk) begin
		if (!resetn) begin
			result_valid_ff <= 1'b0;
			result_code_ff <= 4'h0;
			result_verbose_ff <= 1'b1;
		end else begin
			result_valid_ff <= 1'b0;
			result_verbose_ff <= ctrl_ff[`MCSI_CTL_VERBOSE];
			if (outcome_valid) begin
				result_valid_ff <= 1'b1;
				result_code_ff <= outcome_code;
				case (outcome_code)
					`MCSI_EV_CONNECT: begin
						if (ctrl_ff[3:0] != 4'd0 && connect_rate == 2'd1) begin
							result_code_ff <= `MCSI_RC_1200;
						end else if (ctrl_ff[3:0] != 4'd0 && connect_rate == 2'd2) begin
							result_code_ff <= `MCSI_RC_2400;
						end
					end
					`MCSI_EV_NO_DIAL_TONE: begin
						if (ctrl_ff[3:0] != 4'd2 && ctrl_ff[3:0] != 4'd4) begin
							result_code_ff <= `MCSI_EV_NO_CARRIER;
						end
					end
					`MCSI_EV_BUSY: begin
						if (ctrl_ff[3:0] < 4'd3) begin
							result_code_ff <= `MCSI_EV_NO_CARRIER;
						end
					end
					`MCSI_EV_NO_ANSWER: begin
						if (ctrl_ff[3:0] != 4'd4) begin
							result_code_ff <= `MCSI_EV_NO_CARRIER;
						end
					end
					default: result_code_ff <= outcome_code;
				endcase
			end else if (wr_en && paddr == `MCSI_OFF_COMMAND && pwdata[3:0] != `MCSI_CMD_REPORT) begin
				result_valid_ff <= 1'b1;
				result_code_ff <= (pwdata[3:0] == 4'h0 || pwdata[3:0] > `MCSI_CMD_STORE) ? `MCSI_EV_ERROR :
					`MCSI_EV_OK;
			end
		end
	end

	// Read mux; reads have no side effects.
	always @* begin
		prdata = 32'h00000000;
		if (rd_en) begin
			if (paddr < 8'hC0 && implemented(idx)) begin
				prdata = {24'h000000, sreg_ff[idx]};
			end else if (paddr == `MCSI_OFF_CONTROL) begin
				prdata = {23'h0, ctrl_ff};
			end else if (paddr == `MCSI_OFF_STATUS) begin
				prdata = {24'h000000, format_ok_ff, answer_ff, tr_pending_ff, command_state_ff,
					carrier_detect_ff, tr_sync_ff[1], cd_sync_ff[1], nv_store_ff};
			end else if (paddr == `MCSI_OFF_RESULT) begin
				prdata = {27'h0, result_verbose_ff, result_code_ff};
			end else if (paddr == `MCSI_OFF_DIAL_MOD) begin
				prdata = {26'h0, dial_action_ff};
			end
		end
	end

endmodule // mcsi_core

// File: core/mcsi_defs.vh
// Constants for the modem command settings interpreter: register offsets,
// reset values, option fields, result codes and timing units.
// Assumes a 50 MHz system clock and an APB master with 32-bit data.
`ifndef MCSI_DEFS_VH
`define MCSI_DEFS_VH

// Parameter register byte offsets (index times four), one word each.
`define MCSI_OFF_ANSWER_RING 8'h00
`define MCSI_OFF_RING_COUNTER 8'h04
`define MCSI_OFF_ESCAPE_CHAR 8'h08
`define MCSI_OFF_CR_CHAR 8'h0C
`define MCSI_OFF_LF_CHAR 8'h10
`define MCSI_OFF_BS_CHAR 8'h14
`define MCSI_OFF_DIAL_TONE_WAIT 8'h18
`define MCSI_OFF_CARRIER_WAIT 8'h1C
`define MCSI_OFF_PAUSE_TIME 8'h20
`define MCSI_OFF_CARRIER_VALID 8'h24
`define MCSI_OFF_CARRIER_DROPOUT 8'h28
`define MCSI_OFF_TONE_DURATION 8'h2C
`define MCSI_OFF_ESCAPE_GUARD 8'h30
`define MCSI_OFF_OPTION_A 8'h38
`define MCSI_OFF_TEST_SELECT 8'h40
`define MCSI_OFF_SPECIAL_TEST 8'h44
`define MCSI_OFF_TEST_TIMER 8'h48
`define MCSI_OFF_OPTION_B 8'h54
`define MCSI_OFF_OPTION_C 8'h58
`define MCSI_OFF_OPTION_D 8'h5C
`define MCSI_OFF_TR_DELAY 8'h64
`define MCSI_OFF_CTS_DELAY 8'h68
`define MCSI_OFF_OPTION_E 8'h6C
`define MCSI_OFF_LINE_SPEED 8'h94
// Control, command, status, result and dial modifier registers.
`define MCSI_OFF_CONTROL 8'hC0
`define MCSI_OFF_COMMAND 8'hC4
`define MCSI_OFF_STATUS 8'hC8
`define MCSI_OFF_RESULT 8'hCC
`define MCSI_OFF_DIAL_MOD 8'hD0

// Reset values of the parameter registers, and the write range limits.
`define MCSI_RST_ESCAPE 8'h2B
`define MCSI_RST_CR 8'h0D
`define MCSI_RST_LF 8'h0A
`define MCSI_RST_BS 8'h08
`define MCSI_RST_DIAL_TONE 8'h02
`define MCSI_RST_CARRIER_WAIT 8'h1E
`define MCSI_RST_PAUSE 8'h02
`define MCSI_RST_CARRIER_VALID 8'h06
`define MCSI_RST_CARRIER_DROP 8'h0E
`define MCSI_RST_TONE 8'h46
`define MCSI_RST_GUARD 8'h32
`define MCSI_RST_OPTION_A 8'hAA
`define MCSI_RST_SPECIAL 8'h60
`define MCSI_RST_OPTION_C 8'h76
`define MCSI_RST_OPTION_D 8'h07
`define MCSI_RST_TR_DELAY 8'h05
`define MCSI_RST_CTS_DELAY 8'h01
`define MCSI_RST_OPTION_E 8'h40
`define MCSI_MAX_ASCII 8'h7F
`define MCSI_MAX_SPEED 8'h03

// Control register fields.
`define MCSI_CTL_LEVEL_LSB 0
`define MCSI_CTL_VERBOSE 4
`define MCSI_CTL_CARRIER 5
`define MCSI_CTL_TR_LSB 6
`define MCSI_CTL_LONG_SPACE 8
`define MCSI_CTL_RST 9'h010

// Command codes written to the command register.
`define MCSI_CMD_LEVEL 4'h1
`define MCSI_CMD_CARRIER 4'h2
`define MCSI_CMD_TERMINAL 4'h3
`define MCSI_CMD_LONG_SPACE 4'h4
`define MCSI_CMD_RESET 4'h5
`define MCSI_CMD_FACTORY 4'h6
`define MCSI_CMD_STORE 4'h7
`define MCSI_CMD_REPORT 4'h8

// Outcome codes presented by the call logic, and terse result codes.
`define MCSI_EV_OK 4'h0
`define MCSI_EV_CONNECT 4'h1
`define MCSI_EV_RING 4'h2
`define MCSI_EV_NO_CARRIER 4'h3
`define MCSI_EV_ERROR 4'h4
`define MCSI_EV_NO_DIAL_TONE 4'h6
`define MCSI_EV_BUSY 4'h7
`define MCSI_EV_NO_ANSWER 4'h8
`define MCSI_RC_1200 4'h5
`define MCSI_RC_2400 4'hA

// Timing units.
`define MCSI_CLK_HZ 50000000
`define MCSI_UNIT_10MS_CYC (`MCSI_CLK_HZ / 100)

`endif

// File: verification/mcsi_monitor.sv
// Checker for mcsi_core: result, dial, format, carrier and pulse timing.
// Assumes it is bound to the core and sees only the core's ports.
module mcsi_monitor (
	input wire clk,
	input wire resetn,
	input wire rx_carrier_pin,
	input wire outcome_valid,
	input wire [7:0] dial_char,
	input wire dial_char_valid,
	input wire [1:0] frame_rate,
	input wire [2:0] frame_format,
	input wire carrier_detect_ff,
	input wire hangup_ff,
	input wire nv_store_ff,
	input wire [5:0] dial_action_ff,
	input wire format_ok_ff,
	input wire result_valid_ff,
	input wire [3:0] result_code_ff
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [5:0] exp_dial_ff; // Expected dial action for the next cycle.
	reg [5:0] car_hist_ff; // Recent samples of the carrier pin.
	// Map each dial character to its action bits and keep carrier history.
	always @(posedge clk) begin
		car_hist_ff <= {car_hist_ff[4:0], rx_carrier_pin};
		case (dial_char_valid ? dial_char : 8'h00)
			8'h2C: exp_dial_ff <= 6'h01;
			8'h3B: exp_dial_ff <= 6'h02;
			8'h40: exp_dial_ff <= 6'h04;
			8'h53, 8'h73: exp_dial_ff <= 6'h08;
			8'h21: exp_dial_ff <= 6'h10;
			8'h57, 8'h77: exp_dial_ff <= 6'h20;
			8'h52, 8'h72: exp_dial_ff <= 6'h3F;
			default: exp_dial_ff <= 6'h00;
		endcase
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	result_after_a: assert property (outcome_valid |=> result_valid_ff) else $error("no result");
	code_legal_a: assert property (result_valid_ff |-> result_code_ff != 4'h9 && result_code_ff < 4'hB)
		else $error("bad result code");
	code_hold_a: assert property ($past(resetn) && !result_valid_ff |-> $stable(result_code_ff))
		else $error("result code moved");
	dial_map_a: assert property ($past(resetn) |-> dial_action_ff == exp_dial_ff)
		else $error("dial action wrong");
	format_ok_a: assert property ($past(resetn) && $stable(frame_rate) && $stable(frame_format) |->
		format_ok_ff == (frame_format < 3'h4 || (frame_rate == 2'h0 && frame_format < 3'h6)))
		else $error("format flag wrong");
	carrier_fall_a: assert property ($fell(carrier_detect_ff) |-> car_hist_ff != 6'h3F)
		else $error("carrier fell with carrier present");
	hangup_pulse_a: assert property (hangup_ff |=> !hangup_ff) else $error("hangup too long");
	store_pulse_a: assert property (nv_store_ff |=> !nv_store_ff) else $error("store too long");
endmodule // mcsi_monitor

bind mcsi_core mcsi_monitor i_mon (.clk, .resetn, .rx_carrier_pin, .outcome_valid, .dial_char, .dial_char_valid,
	.frame_rate, .frame_format, .carrier_detect_ff, .hangup_ff, .nv_store_ff, .dial_action_ff, .format_ok_ff,
	.result_valid_ff, .result_code_ff);

// File: verification/mcsi_line_model.sv
// Line and terminal model: drives the pins and call outcomes of the core.
// Assumes its tasks are called right after a rising clock edge.
module mcsi_line_model (
	input wire clk,
	output reg terminal_ready_pin,
	output reg rx_carrier_pin,
	output reg long_space_seen,
	output reg ring_pulse,
	output reg outcome_valid,
	output reg [3:0] outcome_code,
	output reg [1:0] connect_rate,
	output reg [7:0] dial_char,
	output reg dial_char_valid,
	output reg [1:0] frame_rate,
	output reg [2:0] frame_format
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle: terminal ready, carrier present, a legal 8N1 format at 2400.
	initial begin
		terminal_ready_pin = 1'h1;
		rx_carrier_pin = 1'h1;
		long_space_seen = 1'h0;
		ring_pulse = 1'h0;
		outcome_valid = 1'h0;
		outcome_code = 4'h0;
		connect_rate = 2'h0;
		dial_char = 8'h00;
		dial_char_valid = 1'h0;
		frame_rate = 2'h2;
		frame_format = 3'h3;
	end
	// One ring, then an idle cycle.
	task ring;
		begin
			ring_pulse <= 1'h1;
			@(posedge clk);
			ring_pulse <= 1'h0;
			@(posedge clk);
		end
	endtask
	// One long received space.
	task long_space;
		begin
			long_space_seen <= 1'h1;
			@(posedge clk);
			long_space_seen <= 1'h0;
		end
	endtask
	// One outcome; the code lines then show a changed pattern.
	task outcome(input [3:0] c, input [1:0] r);
		begin
			outcome_code <= c;
			connect_rate <= r;
			outcome_valid <= 1'h1;
			@(posedge clk);
			outcome_valid <= 1'h0;
			outcome_code <= ~c;
		end
	endtask
	// One dial character, then an idle cycle.
	task dial(input [7:0] c);
		begin
			dial_char <= c;
			dial_char_valid <= 1'h1;
			@(posedge clk);
			dial_char_valid <= 1'h0;
			dial_char <= ~c;
			@(posedge clk);
		end
	endtask
endmodule // mcsi_line_model

// File: verification/tb_modem_command_settings_interpreter.sv
// Self-checking bench for mcsi_core over APB with the line model.
// Assumes a 50 MHz clock and a short 10 ms unit of four cycles.
`include "mcsi_defs.vh"
module tb_modem_command_settings_interpreter;
	timeunit 1ns;
	timeprecision 1ps;
	reg clk, resetn, psel, penable, pwrite, err;
	reg [7:0] paddr;
	reg [31:0] pwdata, rd, nv_seen;
	wire pready, pslverr, terminal_ready_pin, rx_carrier_pin, long_space_seen, ring_pulse, outcome_valid;
	wire dial_char_valid, carrier_detect_ff, hangup_ff, command_state_ff, modem_reset_ff, answer_ff, nv_store_ff;
	wire format_ok_ff, result_valid_ff, result_verbose_ff;
	wire [31:0] prdata, nv_data_ff;
	wire [3:0] outcome_code, result_code_ff;
	wire [1:0] connect_rate, frame_rate;
	wire [7:0] dial_char;
	wire [2:0] frame_format;
	wire [5:0] dial_action_ff;
	integer bad_count = 0, checked = 0, cyc = 0, i, j;
	// Pairs of register offset and reset value.
	reg [15:0] rv [0:23] = '{16'h0000, 16'h0400, 16'h082B, 16'h0C0D, 16'h100A, 16'h1408, 16'h1802, 16'h1C1E,
		16'h2002, 16'h2406, 16'h280E, 16'h2C46, 16'h3032, 16'h38AA, 16'h4000, 16'h4460, 16'h4800, 16'h5400,
		16'h5876, 16'h5C07, 16'h6405, 16'h6801, 16'h6C40, 16'h9400};
	mcsi_core #(.UNIT_CYC(4)) i_dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pready, .prdata, .pslverr, .terminal_ready_pin, .rx_carrier_pin, .long_space_seen, .ring_pulse,
		.outcome_valid, .outcome_code, .connect_rate, .dial_char, .dial_char_valid, .frame_rate, .frame_format,
		.carrier_detect_ff, .hangup_ff, .command_state_ff, .modem_reset_ff, .answer_ff, .nv_store_ff,
		.nv_data_ff, .dial_action_ff, .format_ok_ff, .result_valid_ff, .result_code_ff, .result_verbose_ff);
	mcsi_line_model i_line (.clk, .terminal_ready_pin, .rx_carrier_pin, .long_space_seen, .ring_pulse,
		.outcome_valid, .outcome_code, .connect_rate, .dial_char, .dial_char_valid, .frame_rate, .frame_format);
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	// Keep the last stored word; a hang ends the run as a mismatch.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (nv_store_ff === 1'h1) nv_seen <= nv_data_ff;
		if (cyc == 20000) begin
			bad_count = bad_count + 1;
			print_verdict;
		end
	end
	task check(input [8*6:1] nm, input [31:0] e, input [31:0] g);
		begin
			checked = checked + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("[FAIL] %0s expected %0h seen %0h", nm, e, g);
			end
		end
	endtask
	// One APB transfer, then an idle cycle.
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			psel <= 1'h1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'h1;
			@(posedge clk);
			while (pready !== 1'h1) @(posedge clk);
			rd = prdata;
			err = pslverr;
			psel <= 1'h0;
			penable <= 1'h0;
			@(posedge clk);
		end
	endtask
	// Terse code expected at level l for outcome case j.
	function [3:0] exp_rc(input integer l, input integer j);
		case (j)
			0: exp_rc = 4'h1;
			1: exp_rc = l ? 4'h5 : 4'h1;
			2: exp_rc = l ? 4'hA : 4'h1;
			3: exp_rc = (l == 2 || l == 4) ? 4'h6 : 4'h3;
			4: exp_rc = l > 2 ? 4'h7 : 4'h3;
			5: exp_rc = l == 4 ? 4'h8 : 4'h3;
			default: exp_rc = j == 6 ? 4'h0 : j - 5;
		endcase
	endfunction
	task print_verdict;
		begin
			$display("checks %0d mismatches %0d", checked, bad_count);
			if (bad_count == 0 && checked > 0) $display("Testbench passed");
			else $display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		{resetn, psel, penable, pwrite, paddr, pwdata, nv_seen} = 0;
		repeat (5) @(posedge clk);
		resetn <= 1'h1;
		@(posedge clk);
		for (i = 0; i < 24; i++) begin
			apb(0, rv[i][15:8], 0);
			check("reset", rv[i][7:0], rd);
		end
		apb(0, 8'h34, 0);
		check("slverr", 32'h00000001, {31'h0, err});
		check("slvrd", 32'h00000000, rd);
		apb(1, `MCSI_OFF_ESCAPE_CHAR, 32'hC8);
		apb(0, `MCSI_OFF_ESCAPE_CHAR, 0);
		check("clamp", 32'h7F, rd);
		apb(1, `MCSI_OFF_LINE_SPEED, 32'h5);
		apb(0, `MCSI_OFF_LINE_SPEED, 0);
		check("speed", 32'h3, rd);
		// Level 0 is written with an empty value field.
		for (i = 4; i >= 0; i--) begin
			apb(1, `MCSI_OFF_COMMAND, i << 4 | 1);
			for (j = 0; j < 10; j++) begin
				i_line.outcome(j < 3 ? 4'h1 : j < 6 ? j + 3 : exp_rc(0, j), j < 3 ? j : 0);
				@(posedge clk);
				check("rcode", {1'h1, exp_rc(i, j)}, {result_valid_ff, result_code_ff});
			end
		end
		check("verb", 1, result_verbose_ff);
		i_line.rx_carrier_pin <= 1'h0;
		repeat (8) @(posedge clk);
		check("cdon", 1, carrier_detect_ff);
		apb(1, `MCSI_OFF_COMMAND, 32'h12);
		repeat (8) @(posedge clk);
		check("cdtrk", 0, carrier_detect_ff);
		i_line.rx_carrier_pin <= 1'h1;
		repeat (8) @(posedge clk);
		check("cdtrk", 1, carrier_detect_ff);
		for (i = 0; i < 4; i++) begin
			apb(1, `MCSI_OFF_COMMAND, i << 4 | 3);
			i_line.terminal_ready_pin <= 1'h0;
			j = 0;
			repeat (60) begin
				@(posedge clk);
				j = j | {modem_reset_ff, hangup_ff};
			end
			check("dtr", {i == 3, i == 2}, j);
			check("cmd", i != 0, command_state_ff);
			i_line.terminal_ready_pin <= 1'h1;
			repeat (8) @(posedge clk);
		end
		for (i = 0; i < 2; i++) begin
			apb(1, `MCSI_OFF_COMMAND, i << 4 | 4);
			i_line.long_space();
			j = 0;
			repeat (4) begin
				@(posedge clk);
				j = j | hangup_ff;
			end
			check("lspace", i, j);
		end
		repeat (3) i_line.ring();
		apb(0, `MCSI_OFF_RING_COUNTER, 0);
		check("rings", 3, rd);
		check("noans", 0, answer_ff);
		apb(1, `MCSI_OFF_RING_COUNTER, 0);
		apb(1, `MCSI_OFF_ANSWER_RING, 2);
		repeat (2) i_line.ring();
		repeat (3) @(posedge clk);
		check("answer", 1, answer_ff);
		apb(1, `MCSI_OFF_COMMAND, 32'h7);
		@(posedge clk);
		check("store", 32'h0105AA02, nv_seen);
		apb(1, `MCSI_OFF_COMMAND, 32'h6);
		apb(0, `MCSI_OFF_ANSWER_RING, 0);
		check("recall", 0, rd);
		for (i = 0; i < 7; i++) i_line.dial(56'h2C3B4073215752 >> (48 - 8 * i));
		check("dial", 6'h3F, dial_action_ff);
		for (i = 0; i < 18; i++) begin
			i_line.frame_rate <= i / 6;
			i_line.frame_format <= i % 6;
			repeat (3) @(posedge clk);
			check("format", i < 6 || i % 6 < 4, format_ok_ff);
		end
		// Unknown command code answers with the error result.
		apb(1, `MCSI_OFF_COMMAND, 32'h9);
		check("cmderr", {1'h1, `MCSI_EV_ERROR}, {result_valid_ff, result_code_ff});
		apb(1, `MCSI_OFF_COMMAND, 32'h5);
		check("zreset", 1, modem_reset_ff);
		// Control readback and terse result form.
		apb(1, `MCSI_OFF_CONTROL, 32'h1A3);
		apb(0, `MCSI_OFF_CONTROL, 0);
		check("ctrl", 32'h1A3, rd);
		check("verb", 0, result_verbose_ff);
		print_verdict;
	end
endmodule // tb_modem_command_settings_interpreter
